/* dhpc_params.svh */
// Constants shared by the hook and path control ends
`ifndef DHPC_PARAMS_SVH
`define DHPC_PARAMS_SVH
`define DHPC_CLK_MHZ         100
`define DHPC_US2CYC(us)      ((us) * `DHPC_CLK_MHZ)
`define DHPC_SETTLE_SEL0_US  128000
`define DHPC_SETTLE_SEL1_US  256000
`define DHPC_SETTLE_SEL2_US  384000
`define DHPC_SETTLE_SEL3_US  8000
`define DHPC_CAL_US          140000
`define DHPC_RCAL_US         6750
`define DHPC_OPE_WAIT_US     25000
`define DHPC_ILIM0_MA        8'hA0
`define DHPC_ILIM1_MA        8'h3C
`define DHPC_LOCK_EDGES      7'h40
`define DHPC_COARSE_GAIN_MAX 4'hC
`define DHPC_BCLK_HALF       6'h19
`define DHPC_FRAME_BITS      10'h0FA
`define DHPC_NARROW_BITS     5'h08
`define DHPC_WIDE_BITS       5'h10
`define DHPC_COEF_SHIFT      6
`define DHPC_OFS_CTRL        8'h00
`define DHPC_OFS_GAIN        8'h04
`define DHPC_OFS_HYB_LO      8'h08
`define DHPC_OFS_HYB_HI      8'h0C
`define DHPC_OFS_TXDATA      8'h10
`define DHPC_OFS_STATUS      8'h14
`define DHPC_CTRL_HOOK       0
`define DHPC_CTRL_CALSKIP    1
`define DHPC_CTRL_RCALSKIP   2
`define DHPC_CTRL_SEL_LO     3
`define DHPC_CTRL_TXMUTE     5
`define DHPC_CTRL_RXMUTE     6
`define DHPC_CTRL_OPE        7
`define DHPC_CTRL_CURRENT_LIMIT_SELECT       8
`define DHPC_CTRL_IIR        9
`define DHPC_CTRL_HP200      10
`define DHPC_CTRL_HSR        11
`define DHPC_CTRL_UPMUTE     12
`define DHPC_CTRL_RESET      13'h0000
`endif

/* dhpc_pkg.sv */
// Types shared by the hook and path control ends
`default_nettype none
package dhpc_pkg;
  typedef enum logic [4:0] {
    DHPC_ST_ON     = 5'h01,
    DHPC_ST_SETTLE = 5'h02,
    DHPC_ST_CAL    = 5'h04,
    DHPC_ST_RCAL   = 5'h08,
    DHPC_ST_READY  = 5'h10
  } dhpc_hook_state_t;
  typedef logic signed [7:0] dhpc_coef_t;
endpackage : dhpc_pkg
`default_nettype wire

/* dhpc_link_if.sv */
// Highway and control link between host and line-access device
`default_nettype none
interface dhpc_link_if;
  logic        bit_clk;
  logic        highway_frame_sync;
  logic        host_data;
  logic        transmit_data_out;
  logic        transmit_data_oe_n;
  logic        dtx_line;
  logic        hook_control;
  logic        calibration_skip;
  logic        resistor_calibration_skip;
  logic [1:0]  offhook_counter_select;
  logic        transmit_mute;
  logic        receive_mute;
  logic        overload_protect_enable;
  logic        current_limit_select;
  logic [3:0]  transmit_coarse_gain;
  logic        transmit_coarse_direction;
  logic [3:0]  transmit_fine_gain;
  logic        transmit_fine_direction;
  logic [3:0]  receive_coarse_gain;
  logic        receive_coarse_direction;
  logic [3:0]  receive_fine_gain;
  logic        receive_fine_direction;
  logic [63:0] hybrid_coefs;
  logic        filter_type_select;
  logic        receive_highpass_select;
  logic        high_sample_rate_select;
  logic [7:0]  line_voltage_status;
  logic        overload_detected;
  logic        path_ready;
  // Pulled high when undriven
  assign dtx_line = transmit_data_oe_n ? 1'b1 : transmit_data_out;
  modport dev (
    input  bit_clk, highway_frame_sync, host_data, hook_control, calibration_skip,
           resistor_calibration_skip, offhook_counter_select, transmit_mute, receive_mute,
           overload_protect_enable, current_limit_select, transmit_coarse_gain,
           transmit_coarse_direction, transmit_fine_gain, transmit_fine_direction,
           receive_coarse_gain, receive_coarse_direction, receive_fine_gain,
           receive_fine_direction, hybrid_coefs, filter_type_select,
           receive_highpass_select, high_sample_rate_select,
    output transmit_data_out, transmit_data_oe_n, line_voltage_status, overload_detected, path_ready
  );
  modport host (
    output bit_clk, highway_frame_sync, host_data, hook_control, calibration_skip,
           resistor_calibration_skip, offhook_counter_select, transmit_mute, receive_mute,
           overload_protect_enable, current_limit_select, transmit_coarse_gain,
           transmit_coarse_direction, transmit_fine_gain, transmit_fine_direction,
           receive_coarse_gain, receive_coarse_direction, receive_fine_gain,
           receive_fine_direction, hybrid_coefs, filter_type_select,
           receive_highpass_select, high_sample_rate_select,
    input  dtx_line, line_voltage_status, overload_detected, path_ready
  );
endinterface : dhpc_link_if
`default_nettype wire

/* dhpc_device.sv */
// Line-access device end: hook sequencing, overload, signal path, highway
`include "dhpc_params.svh"
`default_nettype none
module dhpc_device
  import dhpc_pkg::*;
#(
  parameter int unsigned SETTLE0_CYC = `DHPC_US2CYC(`DHPC_SETTLE_SEL0_US),
  parameter int unsigned SETTLE1_CYC = `DHPC_US2CYC(`DHPC_SETTLE_SEL1_US),
  parameter int unsigned SETTLE2_CYC = `DHPC_US2CYC(`DHPC_SETTLE_SEL2_US),
  parameter int unsigned SETTLE3_CYC = `DHPC_US2CYC(`DHPC_SETTLE_SEL3_US),
  parameter int unsigned CAL_CYC     = `DHPC_US2CYC(`DHPC_CAL_US),
  parameter int unsigned RCAL_CYC    = `DHPC_US2CYC(`DHPC_RCAL_US)
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Link
  dhpc_link_if.dev               link,
  // Line side
  input  wire logic [15:0]       line_rx_pair,
  input  wire logic [7:0]        line_voltage,
  input  wire logic [7:0]        line_current_ma,
  output logic      [7:0]        line_tx_sample,
  output logic signed [8:0]      tx_gain_db10,
  output logic signed [8:0]      rx_gain_db10,
  output logic                   impedance_800,
  output logic                   filter_iir,
  output logic                   hp_200hz,
  output logic                   rate_16k,
  output logic                   hook_closed,
  output logic                   cal_active
);
  function automatic logic signed [8:0] gain_db10(input logic cdir, input logic [3:0] c,
                                                  input logic fdir, input logic [3:0] f);
    logic        [3:0] cc;
    logic signed [8:0] cv;
    logic signed [8:0] fv;
    cc = (cdir && c > `DHPC_COARSE_GAIN_MAX) ? `DHPC_COARSE_GAIN_MAX : c;
    cv = signed'({5'h00, cc}) * 9'sh00A;
    fv = signed'({5'h00, f});
    gain_db10 = (cdir ? cv : -cv) + (fdir ? fv : -fv);
  endfunction : gain_db10

  function automatic logic [7:0] sat8(input logic signed [19:0] v);
    if (v > 20'sh0007F) sat8 = 8'h7F;
    else if (v < -20'sh00080) sat8 = 8'h80;
    else sat8 = v[7:0];
  endfunction : sat8

  logic [2:0] meta_q, sync_q, prev_q;
  dhpc_hook_state_t st_q, st_d;
  logic [31:0] tmr_q;
  logic [31:0] ld_val;
  logic        ld;
  logic [9:0]  bits_q, ratio_q;
  logic        fs_seen_q, ratio_valid_q;
  logic [6:0]  lock_cnt_q;
  logic        lock_q;
  logic [15:0] tx_sh_q;
  logic [4:0]  tx_cnt_q;
  logic [14:0] rx_sh_q;
  logic [4:0]  rx_cnt_q;
  dhpc_coef_t  hist_q [0:7];
  logic signed [19:0] echo_acc;
  logic [7:0]  lvs_q;
  logic        opd_q;

  wire bclk_rise = sync_q[0] & ~prev_q[0];
  wire bclk_fall = ~sync_q[0] & prev_q[0];
  wire fs_rise   = sync_q[1] & ~prev_q[1];
  wire hs        = link.high_sample_rate_select;
  wire [4:0] nbits = hs ? `DHPC_WIDE_BITS : `DHPC_NARROW_BITS;
  wire ready     = (st_q == DHPC_ST_READY) & lock_q & ratio_valid_q;
  wire onhook    = (st_q == DHPC_ST_ON);
  wire [7:0] thr = link.current_limit_select ? `DHPC_ILIM1_MA : `DHPC_ILIM0_MA;
  wire overload  = link.overload_protect_enable & ~onhook & (line_current_ma >= thr);
  wire [15:0] rx_word = {rx_sh_q, sync_q[2]};
  wire [7:0] rx_first = hs ? rx_word[15:8] : rx_word[7:0];
  wire [7:0] up_first = sat8(signed'({{12{line_rx_pair[15]}}, line_rx_pair[15:8]}) - echo_acc);
  wire [15:0] up_word = link.receive_mute ? 16'h0000 : {up_first, line_rx_pair[7:0]};
  wire [15:0] up_load = hs ? up_word : {up_word[15:8], 8'h00};

  // Settling period chosen by the two-bit counter select
  wire [31:0] settle_cyc = (link.offhook_counter_select == 2'b00) ? SETTLE0_CYC :
                           (link.offhook_counter_select == 2'b01) ? SETTLE1_CYC :
                           (link.offhook_counter_select == 2'b10) ? SETTLE2_CYC : SETTLE3_CYC;

  // Echo estimate from recent transmit samples, 0x40 meaning unity
  always_comb begin
    echo_acc = 20'sh00000;
    for (int i = 0; i < 8; i++) begin
      echo_acc = echo_acc + 20'(signed'(link.hybrid_coefs[i*8 +: 8]) * hist_q[i]);
    end
    echo_acc = echo_acc >>> `DHPC_COEF_SHIFT;
  end

  always_comb begin
    st_d   = st_q;
    ld     = 1'b0;
    ld_val = settle_cyc;
    if (!link.hook_control) begin
      st_d = DHPC_ST_ON;
    end else begin
      case (st_q)
        DHPC_ST_ON: begin
          st_d = DHPC_ST_SETTLE;
          ld   = 1'b1;
        end
        DHPC_ST_SETTLE: if (tmr_q == 32'h0) begin
          if (!link.calibration_skip) begin
            st_d = DHPC_ST_CAL; ld = 1'b1; ld_val = CAL_CYC;
          end else if (!link.resistor_calibration_skip) begin
            st_d = DHPC_ST_RCAL; ld = 1'b1; ld_val = RCAL_CYC;
          end else begin
            st_d = DHPC_ST_READY;
          end
        end
        DHPC_ST_CAL: if (tmr_q == 32'h0) begin
          if (!link.resistor_calibration_skip) begin
            st_d = DHPC_ST_RCAL; ld = 1'b1; ld_val = RCAL_CYC;
          end else begin
            st_d = DHPC_ST_READY;
          end
        end
        DHPC_ST_RCAL: if (tmr_q == 32'h0) st_d = DHPC_ST_READY;
        DHPC_ST_READY: st_d = DHPC_ST_READY;
        default: st_d = DHPC_ST_ON;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_q <= 3'h0; sync_q <= 3'h0; prev_q <= 3'h0;
    end else begin
      meta_q <= {link.host_data, link.highway_frame_sync, link.bit_clk};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q  <= DHPC_ST_ON;
      tmr_q <= 32'h0;
    end else begin
      st_q <= st_d;
      if (ld) tmr_q <= ld_val - 32'h1;
      else if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
    end
  end

  // Ratio is caught from the first full frame and never exposed
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bits_q <= 10'h000; ratio_q <= 10'h000; fs_seen_q <= 1'b0; ratio_valid_q <= 1'b0;
    end else if (fs_rise) begin
      bits_q    <= 10'h001;
      fs_seen_q <= 1'b1;
      if (fs_seen_q && !ratio_valid_q) begin
        ratio_q       <= bits_q;
        ratio_valid_q <= 1'b1;
      end
    end else if (bclk_rise) begin
      bits_q <= bits_q + 10'h001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lock_cnt_q <= 7'h00; lock_q <= 1'b0;
    end else if (bclk_rise && !lock_q) begin
      lock_cnt_q <= lock_cnt_q + 7'h01;
      lock_q     <= (lock_cnt_q == `DHPC_LOCK_EDGES - 7'h01);
    end
  end

  // Upstream shifter; pin released the edge after the last bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_sh_q <= 16'h0000; tx_cnt_q <= 5'h00;
      link.transmit_data_out <= 1'b0; link.transmit_data_oe_n <= 1'b1;
    end else if (!ready) begin
      tx_cnt_q <= 5'h00; link.transmit_data_oe_n <= 1'b1;
    end else if (bclk_rise) begin
      if (fs_rise) begin
        link.transmit_data_out  <= up_load[15];
        link.transmit_data_oe_n <= 1'b0;
        tx_sh_q  <= {up_load[14:0], 1'b0};
        tx_cnt_q <= nbits - 5'h01;
      end else if (tx_cnt_q != 5'h00) begin
        link.transmit_data_out <= tx_sh_q[15];
        tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
        tx_cnt_q <= tx_cnt_q - 5'h01;
      end else begin
        link.transmit_data_oe_n <= 1'b1;
      end
    end
  end

  // Downstream shifter toward the line
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_sh_q <= 15'h0000; rx_cnt_q <= 5'h00; line_tx_sample <= 8'h00;
      for (int i = 0; i < 8; i++) hist_q[i] <= 8'sh00;
    end else if (fs_rise) begin
      rx_cnt_q <= nbits;
    end else if (bclk_fall && rx_cnt_q != 5'h00) begin
      rx_sh_q  <= rx_word[14:0];
      rx_cnt_q <= rx_cnt_q - 5'h01;
      if (rx_cnt_q == 5'h01) begin
        line_tx_sample <= (link.transmit_mute || !ready) ? 8'h00 : rx_first;
        hist_q[0] <= signed'(rx_first);
        for (int i = 1; i < 8; i++) hist_q[i] <= hist_q[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lvs_q <= 8'h00; opd_q <= 1'b0; link.line_voltage_status <= 8'h00;
      link.overload_detected <= 1'b0; link.path_ready <= 1'b0; impedance_800 <= 1'b0;
      tx_gain_db10 <= 9'sh000; rx_gain_db10 <= 9'sh000; filter_iir <= 1'b0;
      hp_200hz <= 1'b0; rate_16k <= 1'b0; hook_closed <= 1'b0; cal_active <= 1'b0;
    end else begin
      if (onhook) lvs_q <= line_voltage;
      // Flag stays until enable drops; a fresh overload wins
      opd_q <= overload | (opd_q & link.overload_protect_enable);
      link.line_voltage_status <= lvs_q;
      link.overload_detected   <= opd_q;
      impedance_800            <= opd_q;
      link.path_ready          <= ready;
      tx_gain_db10 <= gain_db10(link.transmit_coarse_direction, link.transmit_coarse_gain,
                                link.transmit_fine_direction, link.transmit_fine_gain);
      rx_gain_db10 <= gain_db10(link.receive_coarse_direction, link.receive_coarse_gain,
                                link.receive_fine_direction, link.receive_fine_gain);
      filter_iir  <= link.filter_type_select & ~hs;
      hp_200hz    <= link.receive_highpass_select;
      rate_16k    <= hs;
      hook_closed <= ~onhook;
      cal_active  <= (st_q == DHPC_ST_CAL) | (st_q == DHPC_ST_RCAL);
    end
  end
endmodule : dhpc_device
`default_nettype wire

/* dhpc_host.sv */
// Host end: APB register file, highway master and bit clock source
`include "dhpc_params.svh"
`default_nettype none
module dhpc_host
  import dhpc_pkg::*;
#(
  parameter int unsigned OPE_WAIT_CYC = `DHPC_US2CYC(`DHPC_OPE_WAIT_US)
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  dhpc_link_if.host        link,
  // User side
  output logic      [15:0] host_rx_sample
);
  logic [12:0] ctrl_q;
  logic [19:0] gain_q;
  logic [63:0] hyb_q;
  logic [15:0] txdata_q;
  logic [31:0] ope_tmr_q;
  logic [5:0]  div_q;
  logic        bclk_q, highway_frame_sync_q, drx_q;
  logic [9:0]  bit_q;
  logic [15:0] tx_sh_q;
  logic [4:0]  tx_cnt_q;
  logic [14:0] rx_sh_q;
  logic [4:0]  rx_cnt_q;
  logic        dtx_meta_q, dtx_sync_q;

  wire acc      = psel & penable;
  wire wr_en    = acc & pready & pwrite;
  wire hit_ctrl = paddr == `DHPC_OFS_CTRL;
  wire hit_gain = paddr == `DHPC_OFS_GAIN;
  wire hit_hlo  = paddr == `DHPC_OFS_HYB_LO;
  wire hit_hhi  = paddr == `DHPC_OFS_HYB_HI;
  wire hit_txd  = paddr == `DHPC_OFS_TXDATA;
  wire hit_sts  = paddr == `DHPC_OFS_STATUS;
  wire mapped   = hit_ctrl | hit_gain | hit_hlo | hit_hhi | hit_txd | hit_sts;
  wire ope_ok   = ope_tmr_q >= OPE_WAIT_CYC;
  wire hook_up  = pwdata[`DHPC_CTRL_HOOK] & ~ctrl_q[`DHPC_CTRL_HOOK];
  // Enable refused before settling and dropped on each off-hook entry
  wire ope_new  = pwdata[`DHPC_CTRL_OPE] & ~hook_up
                  & (ctrl_q[`DHPC_CTRL_OPE] | ope_ok);
  wire [12:0] ctrl_wr = {pwdata[12:8], ope_new, pwdata[6:0]};
  wire [31:0] status  = {host_rx_sample, 6'h00, link.path_ready, link.overload_detected,
                         link.line_voltage_status};
  wire [31:0] rd = hit_ctrl ? {19'h00000, ctrl_q} : hit_gain ? {12'h000, gain_q} :
                   hit_hlo ? hyb_q[31:0] : hit_hhi ? hyb_q[63:32] :
                   hit_txd ? {16'h0000, txdata_q} : hit_sts ? status : 32'h00000000;
  wire tick     = div_q == `DHPC_BCLK_HALF - 6'h01;
  wire rise     = tick & ~bclk_q;
  wire fall     = tick & bclk_q;
  wire frame0   = bit_q == `DHPC_FRAME_BITS - 10'h001;
  wire hs       = ctrl_q[`DHPC_CTRL_HSR];
  wire [4:0]  nbits = hs ? `DHPC_WIDE_BITS : `DHPC_NARROW_BITS;
  wire [15:0] word  = hs ? txdata_q : {txdata_q[7:0], 8'h00};
  wire [15:0] rx_w  = {rx_sh_q, dtx_sync_q};

  assign link.bit_clk                   = bclk_q;
  assign link.highway_frame_sync        = highway_frame_sync_q;
  assign link.host_data                 = drx_q;
  assign link.hook_control              = ctrl_q[`DHPC_CTRL_HOOK];
  assign link.calibration_skip          = ctrl_q[`DHPC_CTRL_CALSKIP];
  assign link.resistor_calibration_skip = ctrl_q[`DHPC_CTRL_RCALSKIP];
  assign link.offhook_counter_select    = ctrl_q[`DHPC_CTRL_SEL_LO +: 2];
  assign link.transmit_mute             = ctrl_q[`DHPC_CTRL_TXMUTE];
  assign link.receive_mute              = ctrl_q[`DHPC_CTRL_RXMUTE];
  assign link.overload_protect_enable   = ctrl_q[`DHPC_CTRL_OPE];
  assign link.current_limit_select      = ctrl_q[`DHPC_CTRL_CURRENT_LIMIT_SELECT];
  assign link.filter_type_select        = ctrl_q[`DHPC_CTRL_IIR];
  assign link.receive_highpass_select   = ctrl_q[`DHPC_CTRL_HP200];
  assign link.high_sample_rate_select   = hs;
  assign link.transmit_coarse_gain      = gain_q[3:0];
  assign link.transmit_coarse_direction = gain_q[4];
  assign link.transmit_fine_gain        = gain_q[8:5];
  assign link.transmit_fine_direction   = gain_q[9];
  assign link.receive_coarse_gain       = gain_q[13:10];
  assign link.receive_coarse_direction  = gain_q[14];
  assign link.receive_fine_gain         = gain_q[18:15];
  assign link.receive_fine_direction    = gain_q[19];
  assign link.hybrid_coefs              = hyb_q;

  // One wait state so read data leaves a flip-flop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0; pslverr <= 1'b0; prdata <= 32'h00000000;
    end else begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & ~mapped;
      if (acc && !pready) prdata <= rd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= `DHPC_CTRL_RESET; gain_q <= 20'h00000; hyb_q <= 64'h0; txdata_q <= 16'h0000;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_q <= ctrl_wr;
      if (hit_gain) gain_q <= pwdata[19:0];
      if (hit_hlo) hyb_q[31:0] <= pwdata;
      if (hit_hhi) hyb_q[63:32] <= pwdata;
      if (hit_txd) txdata_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !ctrl_q[`DHPC_CTRL_HOOK]) ope_tmr_q <= 32'h0;
    else if (!ope_ok) ope_tmr_q <= ope_tmr_q + 32'h1;
  end

  // Bit clock and frame sync from a divider of the system clock
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_q <= 6'h00; bclk_q <= 1'b0; bit_q <= 10'h000; highway_frame_sync_q <= 1'b0;
    end else begin
      div_q <= tick ? 6'h00 : div_q + 6'h01;
      if (tick) bclk_q <= ~bclk_q;
      if (rise) begin
        bit_q   <= frame0 ? 10'h000 : bit_q + 10'h001;
        highway_frame_sync_q <= frame0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drx_q <= 1'b0; tx_sh_q <= 16'h0000; tx_cnt_q <= 5'h00; rx_sh_q <= 15'h0000;
      rx_cnt_q <= 5'h00; host_rx_sample <= 16'h0000; dtx_meta_q <= 1'b1; dtx_sync_q <= 1'b1;
    end else begin
      dtx_meta_q <= link.dtx_line;
      dtx_sync_q <= dtx_meta_q;
      if (rise) begin
        if (frame0 && link.path_ready) begin
          drx_q    <= word[15];
          tx_sh_q  <= {word[14:0], 1'b0};
          tx_cnt_q <= nbits - 5'h01;
          rx_cnt_q <= nbits;
        end else if (tx_cnt_q != 5'h00) begin
          drx_q    <= tx_sh_q[15];
          tx_sh_q  <= {tx_sh_q[14:0], 1'b0};
          tx_cnt_q <= tx_cnt_q - 5'h01;
        end else begin
          drx_q <= 1'b0;
        end
      end else if (fall && rx_cnt_q != 5'h00) begin
        rx_sh_q  <= rx_w[14:0];
        rx_cnt_q <= rx_cnt_q - 5'h01;
        if (rx_cnt_q == 5'h01) begin
          // Upstream mute hides the reply tone and caller data
          host_rx_sample <= ctrl_q[`DHPC_CTRL_UPMUTE] ? 16'h0000 :
                            hs ? rx_w : {8'h00, rx_w[7:0]};
        end
      end
    end
  end
endmodule : dhpc_host
`default_nettype wire

/* dhpc_link_monitor.sv */
// Link checker: hook, overload and clock timing
`default_nettype none
module dhpc_link_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic bit_clk,
  input wire logic highway_frame_sync,
  input wire logic transmit_data_oe_n,
  input wire logic hook_control,
  input wire logic overload_protect_enable,
  input wire logic overload_detected,
  input wire logic path_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_onhook; !hook_control[*3]; endsequence
  sequence s_ope_off; !overload_protect_enable[*3]; endsequence
  chk_onhook_ready: assert property (s_onhook |=> !path_ready) else $error("ready on-hook");
  chk_onhook_quiet: assert property (!hook_control[*8] |-> transmit_data_oe_n) else $error("pin driven");
  chk_settle_block: assert property ($rose(hook_control) |=> !path_ready[*8]) else $error("early ready");
  chk_ready_hook: assert property (path_ready |-> $past(hook_control, 2)) else $error("ready unhooked");
  chk_ovl_clear: assert property (s_ope_off |-> !overload_detected) else $error("flag kept");
  chk_ovl_cause: assert property ($rose(overload_detected) |-> $past(overload_protect_enable, 2))
    else $error("flag unarmed");
  chk_highway_frame_sync_width: assert property ($rose(highway_frame_sync) |-> highway_frame_sync[*8]) else $error("short sync");
  chk_bclk_half: assert property ($rose(bit_clk) |=> bit_clk[*8]) else $error("short clock");
endmodule : dhpc_link_monitor
`default_nettype wire

/* daa_hook_and_path_control_tb.sv */
// Bench: APB host joined to the device
`default_nettype none
module daa_hook_and_path_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready;
  logic        pe, imp, fi, hp, r16, hc, ca, cs;
  logic [7:0]  paddr = 8'h00, lv = 8'h00, cur = 8'h00, b, lts;
  logic signed [8:0] tg, rg;
  logic [15:0] rx = 16'h0000, t;
  logic [31:0] pwdata = 32'h0, prdata, g, eq[$], mq[$];
  int          num_errors = 0, n_checks = 0, cnt, k, e, c, f, st[2] = '{60, 20};
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rx <= 16'($urandom);
  dhpc_link_if dhpc_link_if_i ();
  dhpc_host #(.OPE_WAIT_CYC(15)) dhpc_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pe),
    .link(dhpc_link_if_i), .host_rx_sample());
  // Selects 00 and 10 keep their long defaults, so only 01 and 11 are exercised
  dhpc_device #(.SETTLE1_CYC(60), .SETTLE3_CYC(20), .CAL_CYC(30), .RCAL_CYC(10)) dhpc_device_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(dhpc_link_if_i), .line_rx_pair(rx), .line_voltage(lv), .line_current_ma(cur),
    .line_tx_sample(lts), .tx_gain_db10(tg), .rx_gain_db10(rg), .impedance_800(imp), .filter_iir(fi),
    .hp_200hz(hp), .rate_16k(r16), .hook_closed(hc), .cal_active(ca));
  dhpc_link_monitor mon_i (.ref_clk(ref_clk), .rst_n(rst_n), .bit_clk(dhpc_link_if_i.bit_clk),
    .highway_frame_sync(dhpc_link_if_i.highway_frame_sync), .transmit_data_oe_n(dhpc_link_if_i.transmit_data_oe_n),
    .hook_control(dhpc_link_if_i.hook_control), .overload_protect_enable(dhpc_link_if_i.overload_protect_enable),
    .overload_detected(dhpc_link_if_i.overload_detected), .path_ready(dhpc_link_if_i.path_ready));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic conclude();
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // Reads note the masked expectation; the watcher below compares it
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n = 0;
    @(posedge ref_clk);
    if (!wr) eq.push_back(d & m);
    if (!wr) mq.push_back(m);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge ref_clk) penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    {psel, penable} <= 2'b00;
    if (n >= 40) chk("pready", 32'h0, 32'h1);
    if (n >= 40) conclude();
  endtask : apb
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("prdata", prdata & mq.pop_front(), eq.pop_front());
      chk("pslverr", {31'h0, pe}, {31'h0, paddr > 8'h14});
    end
  initial begin
    void'($urandom(21456));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // Ready needs two frames of the 2 MHz bit clock
    repeat (26000) @(posedge ref_clk);
    apb(1'b0, 8'h00, 32'h0, '1);
    apb(1'b0, 8'h18, 32'h0, '1);
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 3 : $urandom % 4;
      b = 8'($urandom);
      lv <= b;
      apb(1'b1, 8'h00, 32'({i[0], 1'b1, k[1:0], 1'b0}), 32'h0);
      // Line voltage reaches status two cycles after the device is on-hook
      repeat (3) @(posedge ref_clk);
      chk("hook_closed", {31'h0, hc}, 32'h0);
      apb(1'b0, 8'h14, {24'h0, b}, 32'h2FF);
      apb(1'b1, 8'h00, 32'({i[0], 1'b1, k[1:0], 1'b1}), 32'h0);
      cnt = 0;
      cs = 1'b0;
      while (dhpc_link_if_i.path_ready !== 1'b1 && cnt < 900) begin
        @(posedge ref_clk);
        cnt++;
        cs = cs | ca;
      end
      e = st[i % 2] + (k[0] ? 0 : 30) + (k[1] ? 0 : 10);
      chk("settle", 32'(cnt + 2 >= e && cnt <= e + 8), 32'h1);
      chk("cal_active", {31'h0, cs}, 32'(k != 3));
      chk("hook_closed", {31'h0, hc}, 32'h1);
      if (cnt >= 900) conclude();
    end
    for (int l = 0; l < 2; l++) begin
      b = l ? 8'h3C : 8'hA0;
      cur <= b - 8'h01;
      apb(1'b1, 8'h00, 32'({l[0], 8'h9F}), 32'h0);
      apb(1'b0, 8'h14, 32'h0, 32'h100);
      cur <= b;
      repeat (3) @(posedge ref_clk);
      chk("impedance_800", {31'h0, imp}, 32'h1);
      apb(1'b0, 8'h14, 32'h100, 32'h100);
      apb(1'b1, 8'h00, 32'h1F, 32'h0);
      apb(1'b0, 8'h14, 32'h0, 32'h100);
    end
    g = $urandom;
    apb(1'b1, 8'h04, g, 32'h0);
    repeat (2) @(posedge ref_clk);
    for (int p = 0; p < 2; p++) begin
      c = p ? g[13:10] : g[3:0];
      f = p ? g[18:15] : g[8:5];
      e = ((p ? g[14] : g[4]) ? ((c > 12) ? 12 : c) : -c) * 10 + ((p ? g[19] : g[9]) ? f : -f);
      chk("gain_db10", p ? 32'(rg) : 32'(tg), 32'(e));
    end
    // Each setting is given more than a whole frame so a clean frame completes under it
    t = 16'($urandom);
    apb(1'b1, 8'h10, {16'h0000, t}, 32'h0);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h00, (m == 0) ? 32'h65F : (m == 1) ? 32'hA5F : 32'h83F, 32'h0);
      repeat (13500) @(posedge ref_clk);
      chk("line_tx_sample", {24'h0, lts}, {24'h0, (m == 0) ? t[7:0] : (m == 1) ? t[15:8] : 8'h00});
      chk("filter_iir", {31'h0, fi}, 32'(m == 0));
      chk("hp_200hz", {31'h0, hp}, 32'(m == 0));
      chk("rate_16k", {31'h0, r16}, 32'(m != 0));
      if (m < 2) apb(1'b0, 8'h14, 32'h200, 32'hFFFF0200);
    end
    conclude();
  end
endmodule : daa_hook_and_path_control_tb
`default_nettype wire
